// file: src/cdx_pkg.sv
// Shared constants and types for the clear, decrement, skip and jump datapath
`default_nettype none
package cdx_pkg;
  // Widths
  localparam int DATA_W = 8;
  localparam int INSTR_W = 14;
  localparam int PC_W = 13;
  localparam int FADDR_W = 7;
  localparam int LIT_W = 11;
  localparam int PADDR_W = 8;
  localparam int FILE_DEPTH = 128;
  // Register byte offsets
  localparam logic [7:0] OFF_ACC = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_PC = 8'h08;
  localparam logic [7:0] OFF_PAGE = 8'h0C;
  localparam logic [7:0] OFF_FADDR = 8'h10;
  localparam logic [7:0] OFF_FDATA = 8'h14;
  // Status field positions
  localparam int ST_ZERO_BIT = 0;
  localparam int ST_FLUSH_BIT = 1;
  // Page latch bits copied into the upper program counter
  localparam int PAGE_HI_BIT = 4;
  localparam int PAGE_LO_BIT = 3;
  // Reset values
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [6:0] RST_FADDR = 7'h00;
  localparam logic [12:0] RST_PC = 13'h0000;
  localparam logic RST_ZERO = 1'b0;
  // Instruction encodings
  localparam logic [6:0] ENC_CLEAR_REG = 7'h03;
  localparam logic [6:0] ENC_CLEAR_ACC = 7'h02;
  localparam logic [5:0] ENC_DEC = 6'h03;
  localparam logic [5:0] ENC_DEC_SKIP = 6'h0B;
  localparam logic [5:0] ENC_INC_SKIP = 6'h0F;
  localparam logic [2:0] ENC_JUMP = 3'h5;
  // Field positions inside an instruction word
  localparam int DEST_BIT = 7;
  // Constants of the arithmetic
  localparam logic [7:0] ONE = 8'h01;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [12:0] PC_STEP = 13'h0001;
  localparam logic [12:0] PC_SKIP_STEP = 13'h0002;
  // Execute state: normal, or next fetched word becomes a no-operation
  typedef enum logic [0:0] {
    EXEC = 1'b0,
    FLUSH = 1'b1
  } cdx_exec_e;
  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } cdx_apb_req_s;
  // APB answer to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cdx_apb_rsp_s;
endpackage
`default_nettype wire

// file: src/cdx_exec.sv
`timescale 1ns/1ps
`default_nettype none
module cdx_exec
(
  input wire logic I_CORE_CLK,
  input wire logic I_RESETN,
  input wire logic I_INSTR_VALID,
  input wire logic [13:0] I_INSTR,
  input wire cdx_pkg::cdx_apb_req_s I_APB,
  output cdx_pkg::cdx_apb_rsp_s O_APB,
  output logic [7:0] O_ACC,
  output logic O_ZERO,
  output logic [12:0] O_PC,
  output logic O_FLUSH
);
  import cdx_pkg::*;

  // Data register file, no reset
  logic [DATA_W-1:0] file_mem [FILE_DEPTH];
  // Accumulator and zero flag
  logic [DATA_W-1:0] acc;
  logic zero;
  // Program counter and page latch
  logic [PC_W-1:0] pc;
  logic [DATA_W-1:0] page;
  // Software file window address
  logic [FADDR_W-1:0] faddr;
  // Execute state
  cdx_exec_e state;
  // APB answer flops
  logic pready;
  logic pslverr;
  logic [31:0] prdata;

  // Instruction fields
  logic [FADDR_W-1:0] fa;
  logic dest;
  logic [LIT_W-1:0] lit;
  logic [DATA_W-1:0] file_q;
  logic [DATA_W-1:0] inc_val;
  logic [DATA_W-1:0] dec_val;
  // Decoded strobes, only while executing
  logic ex;
  logic op_clr_reg;
  logic op_clr_acc;
  logic op_dec;
  logic op_dec_skip;
  logic op_inc_skip;
  logic op_jump;
  // Step result for register ops
  logic [DATA_W-1:0] res;
  logic res_valid;
  logic skip_now;
  // APB strobes
  logic apb_setup;
  logic apb_wr;

  // Field extraction
  assign fa = I_INSTR[FADDR_W-1:0];
  assign dest = I_INSTR[DEST_BIT];
  assign lit = I_INSTR[LIT_W-1:0];
  assign file_q = file_mem[fa];
  // Wrapping arithmetic
  assign inc_val = file_q + ONE;
  assign dec_val = file_q - ONE;

  // Word is executed only outside a flush cycle
  assign ex = I_INSTR_VALID && (state == EXEC);

  // Opcode decode
  always_comb
  begin
    op_clr_reg = ex && (I_INSTR[13:7] == ENC_CLEAR_REG);
    op_clr_acc = ex && (I_INSTR[13:7] == ENC_CLEAR_ACC);
    op_dec = ex && (I_INSTR[13:8] == ENC_DEC);
    op_dec_skip = ex && (I_INSTR[13:8] == ENC_DEC_SKIP);
    op_inc_skip = ex && (I_INSTR[13:8] == ENC_INC_SKIP);
    op_jump = ex && (I_INSTR[13:11] == ENC_JUMP);
  end

  // Result of decrement and skip forms
  always_comb
  begin
    res = ZERO8;
    res_valid = 1'b0;
    if (op_dec || op_dec_skip)
    begin
      // Decremented value
      res = dec_val;
      res_valid = 1'b1;
    end
    else if (op_inc_skip)
    begin
      // Incremented value
      res = inc_val;
      res_valid = 1'b1;
    end
  end

  // Skip when a skip form lands on zero
  assign skip_now = (op_dec_skip || op_inc_skip) && (res == ZERO8);

  // APB phases
  assign apb_setup = I_APB.psel && !I_APB.penable;
  assign apb_wr = I_APB.psel && I_APB.penable && I_APB.pwrite && pready;

  // Data register file writes; the core wins over software
  always_ff @(posedge I_CORE_CLK)
  begin
    if (op_clr_reg)
    begin
      // Clear addressed register
      file_mem[fa] <= ZERO8;
    end
    else if (res_valid && dest)
    begin
      // Write back to register
      file_mem[fa] <= res;
    end
    else if (apb_wr && (I_APB.paddr == OFF_FDATA))
    begin
      // Software write through the window
      file_mem[faddr] <= I_APB.pwdata[DATA_W-1:0];
    end
  end

  // Accumulator
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
    begin
      acc <= RST_ACC;
    end
    else if (op_clr_acc)
    begin
      // Clear accumulator
      acc <= ZERO8;
    end
    else if (res_valid && !dest)
    begin
      // Result to accumulator, register untouched
      acc <= res;
    end
    else if (apb_wr && (I_APB.paddr == OFF_ACC))
    begin
      // Software write
      acc <= I_APB.pwdata[DATA_W-1:0];
    end
  end

  // Zero flag; skip forms and jump leave it alone
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
    begin
      zero <= RST_ZERO;
    end
    else if (op_clr_reg || op_clr_acc)
    begin
      // Clears force the flag
      zero <= 1'b1;
    end
    else if (op_dec)
    begin
      // Flag follows the decremented value
      zero <= (dec_val == ZERO8);
    end
  end

  // Execute state: one no-operation cycle after a taken skip or a jump
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
    begin
      state <= EXEC;
    end
    else
    begin
      case (state)
        EXEC:
        begin
          // Enter flush on a taken skip or a jump
          if (skip_now || op_jump)
          begin
            state <= FLUSH;
          end
        end
        FLUSH:
        begin
          // Discard the next delivered word
          if (I_INSTR_VALID)
          begin
            state <= EXEC;
          end
        end
        default:
        begin
          state <= EXEC;
        end
      endcase
    end
  end

  // Program counter
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
    begin
      pc <= RST_PC;
    end
    else if (op_jump)
    begin
      // Page bits on top, literal below
      pc <= {page[PAGE_HI_BIT:PAGE_LO_BIT], lit};
    end
    else if (skip_now)
    begin
      // Step over the skipped word
      pc <= pc + PC_SKIP_STEP;
    end
    else if (ex)
    begin
      // Normal advance
      pc <= pc + PC_STEP;
    end
  end

  // Page latch and file window address, software owned
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
    begin
      page <= RST_PAGE;
      faddr <= RST_FADDR;
    end
    else if (apb_wr && (I_APB.paddr == OFF_PAGE))
    begin
      // Page latch write
      page <= I_APB.pwdata[DATA_W-1:0];
    end
    else if (apb_wr && (I_APB.paddr == OFF_FADDR))
    begin
      // Window address write
      faddr <= I_APB.pwdata[FADDR_W-1:0];
    end
  end

  // APB answer: ready in the first access cycle, data taken at setup
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= apb_setup;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (apb_setup)
      begin
        // Address decode
        if (I_APB.paddr == OFF_ACC)
        begin
          prdata <= {24'h000000, acc};
        end
        else if (I_APB.paddr == OFF_STATUS)
        begin
          prdata[ST_ZERO_BIT] <= zero;
          prdata[ST_FLUSH_BIT] <= (state == FLUSH);
        end
        else if (I_APB.paddr == OFF_PC)
        begin
          prdata <= {19'h00000, pc};
        end
        else if (I_APB.paddr == OFF_PAGE)
        begin
          prdata <= {24'h000000, page};
        end
        else if (I_APB.paddr == OFF_FADDR)
        begin
          prdata <= {25'h0000000, faddr};
        end
        else if (I_APB.paddr == OFF_FDATA)
        begin
          prdata <= {24'h000000, file_mem[faddr]};
        end
        else
        begin
          // Unmapped address
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Outputs straight from flops
  assign O_APB = '{pready: pready, pslverr: pslverr, prdata: prdata};
  assign O_ACC = acc;
  assign O_ZERO = zero;
  assign O_PC = pc;
  assign O_FLUSH = (state == FLUSH);

  // Clear register leaves zero and the flag set
  clear_reg_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    op_clr_reg |=> (file_mem[$past(fa)] == ZERO8) && zero)
    else $error("clear register failed");

  // Clear accumulator
  clear_acc_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    op_clr_acc |=> (acc == ZERO8) && zero)
    else $error("clear accumulator failed");

  // Decrement flag
  dec_zero_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    op_dec |=> zero == ($past(file_q) == ONE))
    else $error("decrement zero flag wrong");

  // Decrement into accumulator keeps the source
  dec_to_acc_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    (op_dec && !dest) |=> (acc == 8'($past(file_q) - ONE))
      && (file_mem[$past(fa)] == $past(file_q)))
    else $error("decrement to accumulator wrong");

  // Write back to register
  dec_to_reg_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    ((op_dec || op_dec_skip) && dest) |=> file_mem[$past(fa)] == 8'($past(file_q) - ONE))
    else $error("decrement write back wrong");

  // Taken skip gives one flush with flag kept
  skip_flush_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    skip_now |=> O_FLUSH && $stable(zero))
    else $error("skip did not flush");

  // Increment wrap and skip
  inc_wrap_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    (op_inc_skip && !dest && (file_q == 8'hFF)) |=> (acc == ZERO8) && O_FLUSH)
    else $error("increment wrap failed");

  // Nonzero skip form does not flush
  no_skip_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    ((op_dec_skip || op_inc_skip) && (res != ZERO8)) |=> !O_FLUSH)
    else $error("flush without zero result");

  // Jump target and flag
  jump_pc_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    op_jump |=> (pc == {$past(page[4:3]), $past(lit)}) && O_FLUSH && $stable(zero))
    else $error("jump target wrong");

  // Flushed word changes nothing
  flush_drop_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    (O_FLUSH && I_INSTR_VALID && !apb_wr) |=> $stable(acc) && $stable(zero)
      && $stable(pc) && !O_FLUSH)
    else $error("flushed word executed");

  // APB answers one cycle after setup
  apb_ready_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESETN)
    apb_setup |=> pready ##1 !pready)
    else $error("apb ready timing wrong");
endmodule
`default_nettype wire

// file: bench/cdx_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
// Fetch stage: hands the word at the program counter to the core
module cdx_fetch_model
(
  input wire logic i_en,
  input wire logic i_flush,
  input wire logic [12:0] i_pc,
  output logic o_valid,
  output logic [13:0] o_instr
);
  // Program memory, loaded by the bench
  logic [13:0] rom [64];
  // Empty memory reads as an unlisted opcode
  initial
  begin
    for (int i = 0; i < 64; i++)
      rom[i] = 14'h0000;
  end
  // Slot word in a flush is a jump, so a missed discard shows
  always_comb
  begin
    o_valid = i_en;
    o_instr = i_flush ? 14'h2FFF : rom[i_pc[5:0]];
  end
endmodule
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cdx_pkg::*;
  // Clock, reset, fetch enable
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic en = 1'b0;
  logic valid;
  logic [13:0] instr;
  // Bus request and answer
  cdx_apb_req_s req = '0;
  cdx_apb_rsp_s rsp;
  logic [7:0] acc;
  logic zero;
  logic [12:0] pc;
  logic flush;
  int fail_count = 0;
  int total_checks = 0;
  // Last read data and error
  logic [31:0] rd;
  logic err;
  // Expected pc after each edge of the program
  logic [12:0] exp_pc [12] = '{13'h0001, 13'h0002, 13'h0004, 13'h0004, 13'h0005,
    13'h0006, 13'h0007, 13'h0009, 13'h0009, 13'h000A, 13'h1923, 13'h1923};
  // Expected zero flag and flush, bit i for edge i
  logic [11:0] exp_z = 12'hE20;
  logic [11:0] exp_f = 12'h484;

  // Clock of 40 ns
  always #20 clk = ~clk;

  cdx_exec u_cdx_exec (.I_CORE_CLK(clk), .I_RESETN(rstn), .I_INSTR_VALID(valid),
    .I_INSTR(instr), .I_APB(req), .O_APB(rsp), .O_ACC(acc), .O_ZERO(zero),
    .O_PC(pc), .O_FLUSH(flush));
  cdx_fetch_model u_cdx_fetch_model (.i_en(en), .i_flush(flush), .i_pc(pc),
    .o_valid(valid), .o_instr(instr));

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
  begin
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  end
  endtask

  // Verdict and end of run
  task automatic tally_and_finish();
  begin
    if (fail_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask

  // One bus transfer on rising edges, waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
  begin
    int n;
    n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (rsp.pready !== 1'b1 && n < 8)
    begin
      n++;
      @(posedge clk);
    end
    if (rsp.pready !== 1'b1)
    begin
      fail_count++;
      tally_and_finish();
    end
    // Answer taken at the edge that sees pready, then request released
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  end
  endtask

  // Values straight after reset
  task automatic t_reset();
  begin
    chk(32'(acc), RST_ACC);
    chk(32'(zero), RST_ZERO);
    chk(32'(pc), RST_PC);
    chk(32'(flush), 0);
    apb(1'b0, OFF_PAGE, 0);
    chk(rd, RST_PAGE);
  end
  endtask

  // Program of skips, wraps and a paged jump, traced edge by edge
  task automatic t_program();
  begin
    apb(1'b1, OFF_FADDR, 32'h5);
    apb(1'b1, OFF_FDATA, 32'h2);
    apb(1'b1, OFF_PAGE, 32'h18);
    u_cdx_fetch_model.rom[0] = {ENC_DEC, 1'b0, 7'h05};
    u_cdx_fetch_model.rom[1] = {ENC_DEC, 1'b1, 7'h05};
    u_cdx_fetch_model.rom[2] = {ENC_DEC_SKIP, 1'b1, 7'h05};
    u_cdx_fetch_model.rom[4] = {ENC_INC_SKIP, 1'b1, 7'h05};
    u_cdx_fetch_model.rom[5] = {ENC_CLEAR_REG, 7'h06};
    u_cdx_fetch_model.rom[6] = {ENC_DEC, 1'b1, 7'h06};
    u_cdx_fetch_model.rom[7] = {ENC_INC_SKIP, 1'b0, 7'h06};
    u_cdx_fetch_model.rom[9] = {ENC_CLEAR_ACC, 7'h00};
    u_cdx_fetch_model.rom[10] = {ENC_JUMP, 11'h123};
    @(posedge clk);
    en <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clk);
      #1;
      chk(32'(pc), exp_pc[i]);
      chk(32'(acc), (i < 7) ? 8'h01 : 8'h00);
      chk(32'(zero), exp_z[i]);
      chk(32'(flush), exp_f[i]);
    end
    @(posedge clk);
    en <= 1'b0;
  end
  endtask

  // Register file and state seen over the bus afterwards
  task automatic t_readback();
  begin
    apb(1'b0, OFF_FDATA, 0);
    chk(rd, 32'h01);
    apb(1'b1, OFF_FADDR, 32'h6);
    apb(1'b0, OFF_FDATA, 0);
    chk(rd, 32'hFF);
    apb(1'b0, OFF_STATUS, 0);
    chk(rd, 32'h1);
    apb(1'b0, OFF_PC, 0);
    chk(rd, 32'h1924);
    apb(1'b0, 8'h3C, 0);
    chk(32'(err), 1);
    chk(rd, 0);
  end
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_program();
    t_readback();
    tally_and_finish();
  end
endmodule
`default_nettype wire
